//--- hw/ofm_output_mux.sv
// Output terminal function multiplexer with AXI4-Lite register slave
module ofm_output_mux #(
    parameter int unsigned PLC_PULSE_CYCLES = ofm_pkg::PLC_PULSE_CYC
) (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire ofm_pkg::ofm_cond_t cond_in,
    input wire ofm_pkg::ofm_qty_t pulse_qty_in,
    input wire logic ext_card_present_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic oc_output1_out,
    output logic oc_output2_out,
    output logic dual_purpose_terminal_out,
    output logic relay1_out,
    output logic relay2_out,
    output logic relay3_out
);
    import ofm_pkg::*;

    ofm_state_t st_q;
    ofm_state_t st_d;
    logic [NCODE-1:0] cv;
    logic plc_on;

    // Reserved and out-of-range codes fall through to off
    function automatic logic pick_cond(input logic [4:0] code, input logic [NCODE-1:0] v);
        logic r;
        r = 1'b0;
        if (code <= CODE_MAX) begin
            r = v[code];
        end
        return r;
    endfunction

    function automatic logic is_sel_addr(input logic [7:0] a);
        return (a >= ADDR_SEL0) && (a <= ADDR_SEL5) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return (a == ADDR_MODE) || is_sel_addr(a) || (a == ADDR_PSRC) || (a == ADDR_STATUS);
    endfunction

    assign plc_on = (st_q.plc_cnt != '0);

    // Condition table, index is the selector code
    always_comb begin
        cv = '0;
        cv[0] = 1'b0;
        cv[1] = cond_in.fwd_run;
        cv[2] = cond_in.rev_run;
        cv[3] = cond_in.fault;
        cv[4] = cond_in.motor_ol_warn;
        cv[5] = cond_in.drive_ol_warn;
        cv[6] = cond_in.freq_level_detect;
        cv[7] = cond_in.freq_arrival;
        cv[8] = cond_in.out_freq < cond_in.start_freq;
        cv[9] = cond_in.count_value >= cond_in.total_count_setting;
        cv[10] = cond_in.count_value >= cond_in.assigned_count_setting;
        cv[11] = cond_in.length_value > cond_in.length_setting;
        cv[12] = plc_on;
        cv[13] = cond_in.run_time > cond_in.run_time_setting;
        cv[14] = cond_in.out_freq >= cond_in.upper_freq_limit;
        cv[15] = cond_in.out_freq <= cond_in.lower_freq_limit;
        cv[16] = cond_in.main_power & cond_in.ctrl_power & ~cond_in.protect_active;
        cv[17] = cond_in.boost_pump1;
        cv[18] = cond_in.boost_pump2;
    end

    always_comb begin
        logic [QTY_W-1:0] inc;
        logic [7:0] ra;
        logic [31:0] rd;
        int unsigned wi;
        inc = '0;
        ra = '0;
        rd = '0;
        wi = 0;
        st_d = st_q;

        // Write address and data captured in either order
        if (s_axi_awvalid_in && st_q.awready) begin
            st_d.aw_got = 1'b1;
            st_d.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && st_q.wready) begin
            st_d.w_got = 1'b1;
            st_d.wdata = s_axi_wdata_in;
            st_d.wstrb = s_axi_wstrb_in;
        end
        if (st_q.bvalid && s_axi_bready_in) begin
            st_d.bvalid = 1'b0;
        end
        if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
            st_d.aw_got = 1'b0;
            st_d.w_got = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = is_mapped(st_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            // Only the low byte holds any field
            if (st_q.wstrb[0]) begin
                if (st_q.aw_addr == ADDR_MODE) begin
                    st_d.mode = st_q.wdata[0];
                end
                if (is_sel_addr(st_q.aw_addr)) begin
                    wi = 32'((st_q.aw_addr - ADDR_SEL0) >> 2);
                    if (wi != SEL_RLY3 || ext_card_present_in) begin
                        st_d.sel[wi] = st_q.wdata[4:0];
                    end
                end
                if (st_q.aw_addr == ADDR_PSRC) begin
                    st_d.psrc = st_q.wdata[4:0];
                end
            end
        end

        // Read
        if (st_q.rvalid && s_axi_rready_in) begin
            st_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && st_q.arready) begin
            ra = s_axi_araddr_in;
            if (ra == ADDR_MODE) begin
                rd = {31'h0000_0000, st_q.mode};
            end
            if (is_sel_addr(ra)) begin
                rd = {27'h000_0000, st_q.sel[32'((ra - ADDR_SEL0) >> 2)]};
            end
            if (ra == ADDR_PSRC) begin
                rd = {27'h000_0000, st_q.psrc};
            end
            if (ra == ADDR_STATUS) begin
                rd = {24'h00_0000, plc_on, ext_card_present_in, st_q.term};
            end
            st_d.rvalid = 1'b1;
            st_d.rdata = rd;
            st_d.rresp = is_mapped(ra) ? RESP_OKAY : RESP_SLVERR;
        end
        st_d.awready = !st_d.aw_got && !st_d.bvalid;
        st_d.wready = !st_d.w_got && !st_d.bvalid;
        st_d.arready = !st_d.rvalid;

        // Selector for the missing relay reads back as off
        if (!ext_card_present_in) begin
            st_d.sel[SEL_RLY3] = CODE_OFF;
        end

        // Sequence cycle pulse, retriggered by each completion
        if (cond_in.plc_cycle_done) begin
            st_d.plc_cnt = CNT_W'(PLC_PULSE_CYCLES);
        end else if (plc_on) begin
            st_d.plc_cnt = st_q.plc_cnt - 1'b1;
        end

        // Phase accumulator, 16-bit step over 27 bits peaks below 50 kHz
        if (st_q.psrc < NQTY) begin
            inc = pulse_qty_in[st_q.psrc];
        end
        if (st_q.mode == MODE_PULSE) begin
            st_d.acc = st_q.acc + ACC_W'(inc);
        end else begin
            st_d.acc = '0;
        end

        for (int i = 0; i < NSEL; i++) begin
            st_d.term[i] = pick_cond(st_q.sel[i], cv);
        end
        if (st_q.mode == MODE_PULSE) begin
            st_d.term[SEL_DUAL] = st_q.acc[ACC_W-1];
        end else begin
            st_d.term[SEL_DUAL] = pick_cond(st_q.sel[SEL_DUAL], cv);
        end
        if (!ext_card_present_in) begin
            st_d.term[SEL_RLY3] = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_q <= '0;
            st_q.mode <= MODE_RST;
            st_q.sel <= SEL_RST;
            st_q.psrc <= PSRC_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign s_axi_awready_out = st_q.awready;
    assign s_axi_wready_out = st_q.wready;
    assign s_axi_bvalid_out = st_q.bvalid;
    assign s_axi_bresp_out = st_q.bresp;
    assign s_axi_arready_out = st_q.arready;
    assign s_axi_rvalid_out = st_q.rvalid;
    assign s_axi_rdata_out = st_q.rdata;
    assign s_axi_rresp_out = st_q.rresp;
    assign oc_output1_out = st_q.term[SEL_OC1];
    assign oc_output2_out = st_q.term[SEL_OC2];
    assign dual_purpose_terminal_out = st_q.term[SEL_DUAL];
    assign relay1_out = st_q.term[SEL_RLY1];
    assign relay2_out = st_q.term[SEL_RLY2];
    assign relay3_out = st_q.term[SEL_RLY3];

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);

    sequence s_wr_both;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence s_plc_start;
        cond_in.plc_cycle_done;
    endsequence

    chk_pulse_load: assert property (s_plc_start |=> st_q.plc_cnt == PLC_PULSE_CYCLES)
        else $error("sequence pulse not loaded to full width");
    chk_pulse_run: assert property (plc_on && !cond_in.plc_cycle_done
        |=> st_q.plc_cnt == $past(st_q.plc_cnt) - 1)
        else $error("sequence pulse counter did not step");
    chk_code_zero: assert property (st_q.sel[SEL_OC1] == CODE_OFF |=> !oc_output1_out)
        else $error("code zero terminal not off");
    chk_fault_route: assert property (st_q.sel[SEL_RLY1] == CODE_FAULT && cond_in.fault
        |=> relay1_out)
        else $error("fault not routed to relay");
    chk_reserved_off: assert property (st_q.sel[SEL_OC2] >= CODE_RSV_LO |=> !oc_output2_out)
        else $error("reserved code drove terminal");
    chk_ext_absent: assert property (!ext_card_present_in |=> !relay3_out)
        else $error("relay three active without card");
    chk_switch_mode: assert property (st_q.mode == MODE_SWITCH && st_q.sel[SEL_DUAL] == CODE_FWD
        |=> dual_purpose_terminal_out == $past(cond_in.fwd_run))
        else $error("dual terminal switching wrong");
    chk_freq_bound: assert property (st_q.mode == MODE_PULSE
        |=> ACC_W'(st_q.acc - $past(st_q.acc)) < (ACC_W'(1) << QTY_W))
        else $error("pulse step too large");
    chk_write_resp: assert property (s_wr_both |-> ##2 s_axi_bvalid_out)
        else $error("write response missing");
    chk_read_resp: assert property (s_axi_arvalid_in && s_axi_arready_out
        |=> s_axi_rvalid_out ##1 (s_axi_rvalid_out || $past(s_axi_rready_in)))
        else $error("read response missing");
endmodule

//--- hw/ofm_pkg.sv
// Package for the output terminal function multiplexer
// Overview of operation
// - Mode bit: 0 makes the dual terminal a pulse output, 1 a switching output.
// - Pulse output frequency never exceeds 50.0 kHz.
// - In switching mode the dual terminal uses its own selector and the shared code table.
// - Six selectors take codes 0 to 25, each routing that condition.
// - Reset: output 1 selects code 1, relay 1 code 3, others code 0.
// - Code 0 holds the terminal off.
// - Code 1 means running forward, code 2 running reverse.
// - Code 3 turns on while any fault is present.
// - Codes 4 and 5 show motor and drive overload pre-warnings.
// - Code 6 shows frequency level detect, code 7 frequency arrival.
// - Code 8 turns on while output frequency is below starting frequency.
// - Code 9 turns on when the count reaches the total count setting.
// - Code 10 turns on when the count reaches the assigned count setting.
// - Code 11 turns on when measured length exceeds the length setting.
// - Code 12 gives one 200 ms pulse per sequence program cycle.
// - Code 13 turns on when running time exceeds the run time setting.
// - Code 14 at upper frequency limit, code 15 at lower limit.
// - Code 16 shows ready: both supplies present, no protection active.
// - Codes 17 and 18 start the first and second boost pumps.
// - Relay 3 and its selector exist only with the extension card fitted.
// - A pulse source selector, codes 0 to 14, picks the pulse frequency quantity.
package ofm_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned PLC_PULSE_MS = 200;
    localparam int unsigned PLC_PULSE_CYC = PLC_PULSE_MS * (CLK_HZ / 1000);
    localparam int unsigned PULSE_MAX_HZ = 50_000;
    localparam int unsigned QTY_W = 16;
    localparam int unsigned ACC_W = 27;
    localparam int unsigned NQTY = 15;
    localparam int unsigned NSEL = 6;
    localparam int unsigned NCODE = 26;
    localparam int unsigned CNT_W = 32;

    localparam logic [4:0] CODE_OFF = 5'h00;
    localparam logic [4:0] CODE_FWD = 5'h01;
    localparam logic [4:0] CODE_FAULT = 5'h03;
    localparam logic [4:0] CODE_RSV_LO = 5'h13;
    localparam logic [4:0] CODE_MAX = 5'h19;

    localparam int unsigned SEL_OC1 = 0;
    localparam int unsigned SEL_OC2 = 1;
    localparam int unsigned SEL_DUAL = 2;
    localparam int unsigned SEL_RLY1 = 3;
    localparam int unsigned SEL_RLY2 = 4;
    localparam int unsigned SEL_RLY3 = 5;

    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_SEL0 = 8'h04;
    localparam logic [7:0] ADDR_SEL5 = 8'h18;
    localparam logic [7:0] ADDR_PSRC = 8'h1C;
    localparam logic [7:0] ADDR_STATUS = 8'h20;

    localparam logic MODE_PULSE = 1'b0;
    localparam logic MODE_SWITCH = 1'b1;
    localparam logic MODE_RST = 1'b0;
    localparam logic [4:0] PSRC_RST = 5'h00;
    localparam logic [NSEL-1:0][4:0] SEL_RST = {5'h00, 5'h00, CODE_FAULT, 5'h00, 5'h00, CODE_FWD};

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef logic [NQTY-1:0][QTY_W-1:0] ofm_qty_t;

    typedef struct packed {
        logic fwd_run;
        logic rev_run;
        logic fault;
        logic motor_ol_warn;
        logic drive_ol_warn;
        logic freq_level_detect;
        logic freq_arrival;
        logic plc_cycle_done;
        logic main_power;
        logic ctrl_power;
        logic protect_active;
        logic boost_pump1;
        logic boost_pump2;
        logic [CNT_W-1:0] count_value;
        logic [CNT_W-1:0] total_count_setting;
        logic [CNT_W-1:0] assigned_count_setting;
        logic [CNT_W-1:0] length_value;
        logic [CNT_W-1:0] length_setting;
        logic [CNT_W-1:0] run_time;
        logic [CNT_W-1:0] run_time_setting;
        logic [QTY_W-1:0] out_freq;
        logic [QTY_W-1:0] start_freq;
        logic [QTY_W-1:0] upper_freq_limit;
        logic [QTY_W-1:0] lower_freq_limit;
    } ofm_cond_t;

    typedef struct packed {
        logic mode;
        logic [NSEL-1:0][4:0] sel;
        logic [4:0] psrc;
        logic awready;
        logic wready;
        logic arready;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [ACC_W-1:0] acc;
        logic [CNT_W-1:0] plc_cnt;
        logic [NSEL-1:0] term;
    } ofm_state_t;
endpackage

//--- tb/ofm_load_model.sv
// Far-side load on the dual terminal: counts the pulses it receives
module ofm_load_model (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic clear_in,
    input wire logic pulse_in,
    output logic [15:0] edge_count_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_q;
    // Edges, not periods: a period check would need far longer windows
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            last_q <= 1'b0;
            edge_count_out <= 16'h0000;
        end else begin
            last_q <= pulse_in;
            if (clear_in) begin
                edge_count_out <= 16'h0000;
            end else if (pulse_in && !last_q) begin
                edge_count_out <= edge_count_out + 16'h0001;
            end
        end
    end
endmodule

//--- tb/test_output_terminal_function_mux.sv
// Testbench for the output terminal function multiplexer
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin fails++; \
    $display("mismatch t=%0t act=%h exp=%h", $time, (act), (exp)); end end
module test_output_terminal_function_mux import ofm_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PLC = 20;
    logic mclk = 0, resetn = 0, ext = 0, clr = 0;
    ofm_cond_t cond = '0;
    ofm_qty_t qty = '0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic [15:0] edges;
    wire [5:0] term;
    int fails = 0, checked = 0, n;
    logic [31:0] rst_tab [7] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h3, 32'h0, 32'h0};

    ofm_output_mux #(.PLC_PULSE_CYCLES(PLC)) uut (.mclk_in(mclk), .resetn_in(resetn),
        .cond_in(cond), .pulse_qty_in(qty), .ext_card_present_in(ext),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .oc_output1_out(term[0]),
        .oc_output2_out(term[1]), .dual_purpose_terminal_out(term[2]),
        .relay1_out(term[3]), .relay2_out(term[4]), .relay3_out(term[5]));
    ofm_load_model load (.mclk_in(mclk), .resetn_in(resetn), .clear_in(clr),
        .pulse_in(term[2]), .edge_count_out(edges));

    initial begin
        forever #5 mclk = ~mclk;
    end

    task automatic final_report;
        $display("counts: fails=%0d checked=%0d", fails, checked);
        if (fails == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit aw_on, w_on, ok;
        aw_on = 1;
        w_on = 1;
        ok = 0;
        @(posedge mclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (100) begin
            @(posedge mclk);
            if (aw_on && awready === 1'b1) begin
                aw_on = 0;
                awvalid <= 1'b0;
            end
            if (w_on && wready === 1'b1) begin
                w_on = 0;
                wvalid <= 1'b0;
            end
            if (bvalid === 1'b1) begin
                ok = 1;
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (!ok) begin
            fails++;
            final_report();
        end
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        bit ok;
        ok = 0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        repeat (100) begin
            @(posedge mclk);
            if (arready === 1'b1) begin
                arvalid <= 1'b0;
            end
            if (rvalid === 1'b1) begin
                ok = 1;
                d = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (!ok) begin
            fails++;
            final_report();
        end
    endtask

    // All conditions but the sequence pulse true, or all false with count, length and run time comparisons one step off
    function automatic ofm_cond_t mk(input bit on);
        ofm_cond_t c;
        c = '0;
        {c.fwd_run, c.rev_run, c.fault, c.motor_ol_warn, c.drive_ol_warn} = {5{on}};
        {c.freq_level_detect, c.freq_arrival, c.boost_pump1, c.boost_pump2} = {4{on}};
        c.main_power = 1'b1;
        c.ctrl_power = 1'b1;
        c.protect_active = !on;
        c.count_value = on ? 32'h5 : 32'h4;
        c.total_count_setting = 32'h5;
        c.assigned_count_setting = 32'h5;
        c.length_value = on ? 32'h6 : 32'h5;
        c.length_setting = 32'h5;
        c.run_time = on ? 32'h6 : 32'h5;
        c.run_time_setting = 32'h5;
        c.out_freq = on ? 16'h4 : 16'hA;
        c.start_freq = 16'h5;
        c.upper_freq_limit = on ? 16'h4 : 16'h14;
        c.lower_freq_limit = on ? 16'h4 : 16'h5;
        return c;
    endfunction

    initial begin
        #800_000;
        fails++;
        final_report();
    end

    initial begin
        tick(10);
        resetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd_reg(8'(4 * i), rd);
            `CHK(rd, rst_tab[i])
        end
        rd_reg(8'h40, rd);
        `CHK(resp, RESP_SLVERR)
        cond <= mk(1);
        tick(3);
        `CHK(term[0], 1'b1)
        `CHK(term[3], 1'b1)
        // Relay 3 selector without the card must not stick
        wr(ADDR_SEL5, 32'h3);
        rd_reg(ADDR_SEL5, rd);
        `CHK(rd, 32'h0)
        `CHK(term[5], 1'b0)
        ext <= 1'b1;
        wr(ADDR_SEL5, 32'h3);
        tick(3);
        `CHK(term[5], 1'b1)
        for (int p = 0; p < 2; p++) begin
            cond <= mk(p == 0);
            for (int c = 0; c < 26; c++) begin
                wr(8'h08, 32'(c));
                tick(3);
                `CHK(term[1], 1'((p == 0) && c >= 1 && c <= 18 && c != 12))
            end
        end
        wr(8'h08, 32'hC);
        @(posedge mclk) cond.plc_cycle_done <= 1'b1;
        @(posedge mclk) cond.plc_cycle_done <= 1'b0;
        n = 0;
        repeat (PLC + 10) begin
            @(posedge mclk);
            n += (term[1] === 1'b1);
        end
        `CHK(n, PLC)
        wr(ADDR_MODE, 32'h1);
        wr(8'h0C, 32'h3);
        cond <= mk(1);
        tick(3);
        `CHK(term[2], 1'b1)
        cond <= mk(0);
        tick(3);
        `CHK(term[2], 1'b0)
        qty[0] <= 16'hFFFF;
        wr(ADDR_MODE, 32'h0);
        @(posedge mclk) clr <= 1'b1;
        @(posedge mclk) clr <= 1'b0;
        tick(8192);
        `CHK(edges >= 16'd3 && edges <= 16'd4, 1'b1)
        wr(ADDR_PSRC, 32'h1);
        @(posedge mclk) clr <= 1'b1;
        @(posedge mclk) clr <= 1'b0;
        tick(4096);
        `CHK(edges, 16'h0000)
        cond <= mk(1);
        tick(3);
        resetn <= 1'b0;
        #2;
        `CHK(term, 6'h00)
        tick(3);
        resetn <= 1'b1;
        rd_reg(ADDR_SEL0, rd);
        `CHK(rd, 32'h1)
        final_report();
    end
endmodule
